// *** lpm_pkg.sv ***
// package: constants, states and decode helpers of the low power mode controller
package lpm_pkg;
   localparam int unsigned        ADDR_W        = 12;
   localparam int unsigned        DATA_W        = 32;
   localparam logic [ADDR_W-1:0]  CFG_OFS       = 12'h000;
   localparam logic [ADDR_W-1:0]  STAT_OFS      = 12'h004;
   localparam int unsigned        SLEEP_BIT     = 7;
   localparam int unsigned        SUSP_BIT      = 6;
   localparam int unsigned        CLEAR_BIT     = 5;
   localparam int unsigned        RST_FLAG_BIT  = 4;
   localparam int unsigned        NUM_SRC       = 4;
   localparam int unsigned        FLAG_W        = 5;
   localparam int unsigned        STAT_SUSP_BIT = 0;
   localparam int unsigned        STAT_SLEEP_BIT = 1;
   localparam int unsigned        STAT_HOLD_BIT = 2;
   localparam logic [1:0]         FLAG_HOLD_CYC = 2'h2;
   localparam logic [3:0]         WAKE_REQ_CYC  = 4'h8;

   typedef enum logic [1:0] {ST_RUN, ST_SUSP, ST_SLEEP, ST_HOLD} lpm_state_e;

   function automatic logic lpm_is_low(input lpm_state_e s);
      return (s == ST_SUSP) || (s == ST_SLEEP);
   endfunction : lpm_is_low
endpackage : lpm_pkg

// *** lpm_wake_if.sv ***
// interface: wake source enables, flags and wake event between controller and detector
`timescale 1ns/1ps
interface lpm_wake_if;
   logic [3:0] en;
   logic       clr;
   logic [4:0] flags;
   logic       wake;
   modport ctrl (output en, output clr, input flags, input wake);
   modport det  (input en, input clr, output flags, output wake);
endinterface : lpm_wake_if

// *** lpm_wake_det.sv ***
// module: wake source detection and sticky wake flags
`timescale 1ns/1ps
module lpm_wake_det
   import lpm_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   lpm_wake_if.det   wk,
   input  wire logic cs_done_i,
   input  wire logic rtc_fail_i,
   input  wire logic rtc_alarm_i,
   input  wire logic port_match_i,
   input  wire logic cmp0_i,
   input  wire logic rst_pin_i
);
   logic [FLAG_W-1:0] flags_r, flags_nxt, set_v;
   logic              wake_r, wake_nxt;
   logic              cmp_q_r, cmp_q_nxt, pin_q_r, pin_q_nxt;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      cmp_q_nxt = cmp0_i;
      pin_q_nxt = rst_pin_i;
      set_v[0]  = wk.en[0] & cmp0_i & ~cmp_q_r;
      set_v[1]  = wk.en[1] & port_match_i;
      set_v[2]  = wk.en[2] & rtc_alarm_i;
      set_v[3]  = wk.en[3] & rtc_fail_i;
      set_v[RST_FLAG_BIT] = pin_q_r & ~rst_pin_i;
      // a new event wins over a clear in the same cycle
      flags_nxt = (flags_r & ~{FLAG_W{wk.clr}}) | set_v;
      wake_nxt  = (|set_v) | cs_done_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_r <= 5'h00;
         wake_r  <= 1'b0;
         cmp_q_r <= 1'b0;
         pin_q_r <= 1'b1;
      end else begin
         flags_r <= flags_nxt;
         wake_r  <= wake_nxt;
         cmp_q_r <= cmp_q_nxt;
         pin_q_r <= pin_q_nxt;
      end
   end

   assign wk.flags = flags_r;
   assign wk.wake  = wake_r;

   ////////////////////////////////////////////////////////////////////////////
   a_pin_edge_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($fell(rst_pin_i)) |=> (flags_r[RST_FLAG_BIT] && wake_r))
      else $error("reset pin edge did not set flag and wake");
   a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wk.clr && wk.en[1] && port_match_i) |=> flags_r[1])
      else $error("port match event lost under clear");
   a_clear_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wk.clr && set_v == 5'h00) |=> (flags_r == 5'h00))
      else $error("flags not cleared");
endmodule : lpm_wake_det

// *** lpm_ctrl.sv ***
// module: low power mode controller with APB configuration register
`timescale 1ns/1ps
module lpm_ctrl
   import lpm_pkg::*;
(
   input  wire logic              MCLK_I,
   input  wire logic              RST_N_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [DATA_W-1:0] PWDATA_I,
   output logic      [DATA_W-1:0] PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic              CS_DONE_I,
   input  wire logic              RTC_FAIL_I,
   input  wire logic              RTC_ALARM_I,
   input  wire logic              PORT_MATCH_I,
   input  wire logic              CMP0_I,
   input  wire logic              RST_PIN_I,
   output logic                   SYS_CLK_EN_O,
   output logic                   OSC_EN_O,
   output logic                   LP_OSC_EN_O,
   output logic                   CORE_HALT_O,
   output logic                   CORE_REG_EN_O,
   output logic                   RAM_ON_VDD_O,
   output logic                   LOGIC_PWR_EN_O,
   output logic                   ANALOG_EN_O,
   output logic                   CMP_EN_O,
   output logic                   GPIO_HOLD_O,
   output logic                   PORT_MATCH_EN_O,
   output logic                   WAKE_REQ_N_O
);
   lpm_wake_if wk ();

   lpm_state_e        st_r, st_nxt;
   logic [1:0]        hold_r, hold_nxt;
   logic [3:0]        wreq_r, wreq_nxt;
   logic [NUM_SRC-1:0] en_r, en_nxt;
   logic              clr_r, clr_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic              rdy_r, rdy_nxt, err_r, err_nxt;
   logic              wr_cfg, setup, hit_cfg, hit_stat;
   logic              sclk_r, osc_r, lposc_r, halt_r, vreg_r, ram_r, lpwr_r;
   logic              ana_r, cmp_r, hold_pin_r, pm_r, wreq_n_r;
   logic              sclk_nxt, osc_nxt, lposc_nxt, halt_nxt, vreg_nxt, ram_nxt, lpwr_nxt;
   logic              ana_nxt, cmp_nxt, hold_pin_nxt, pm_nxt, wreq_n_nxt;

   lpm_wake_det u_det (
      .clk_i        (MCLK_I),
      .rst_n_i      (RST_N_I),
      .wk           (wk),
      .cs_done_i    (CS_DONE_I),
      .rtc_fail_i   (RTC_FAIL_I),
      .rtc_alarm_i  (RTC_ALARM_I),
      .port_match_i (PORT_MATCH_I),
      .cmp0_i       (CMP0_I),
      .rst_pin_i    (RST_PIN_I)
   );

   assign wk.en  = en_r;
   assign wk.clr = clr_r;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, answer in first access cycle
   always_comb begin
      setup     = PSEL_I & ~PENABLE_I;
      hit_cfg   = (PADDR_I == CFG_OFS);
      hit_stat  = (PADDR_I == STAT_OFS);
      wr_cfg    = PSEL_I & PENABLE_I & rdy_r & PWRITE_I & hit_cfg & ~err_r;
      rdy_nxt   = setup;
      err_nxt   = setup & ~hit_cfg & ~hit_stat;
      rdata_nxt = 32'h0;
      if (setup && !PWRITE_I && hit_cfg) begin
         // triggers read zero, flags masked right after suspend wake
         if (st_r != ST_HOLD) begin
            rdata_nxt[FLAG_W-1:0] = wk.flags;
         end
      end else if (setup && !PWRITE_I && hit_stat) begin
         rdata_nxt[STAT_SUSP_BIT]  = (st_r == ST_SUSP);
         rdata_nxt[STAT_SLEEP_BIT] = (st_r == ST_SLEEP);
         rdata_nxt[STAT_HOLD_BIT]  = (st_r == ST_HOLD);
      end
      en_nxt  = wr_cfg ? PWDATA_I[NUM_SRC-1:0] : en_r;
      clr_nxt = wr_cfg & PWDATA_I[CLEAR_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencer
   always_comb begin
      st_nxt   = st_r;
      hold_nxt = hold_r;
      wreq_nxt = (wreq_r != 4'h0) ? wreq_r - 4'h1 : 4'h0;
      case (st_r)
         ST_RUN: begin
            // entry refused while any wake flag stands
            if (wr_cfg && (wk.flags == 5'h00)) begin
               if (PWDATA_I[SLEEP_BIT]) begin
                  st_nxt = ST_SLEEP;
               end else if (PWDATA_I[SUSP_BIT]) begin
                  st_nxt = ST_SUSP;
               end
            end
         end
         ST_SUSP: begin
            if (wk.wake || (wk.flags != 5'h00)) begin
               st_nxt   = ST_HOLD;
               hold_nxt = 2'h1;
            end
         end
         ST_HOLD: begin
            if (hold_r >= FLAG_HOLD_CYC) begin
               st_nxt = ST_RUN;
            end else begin
               hold_nxt = hold_r + 2'h1;
            end
         end
         ST_SLEEP: begin
            if (wk.wake || (wk.flags != 5'h00)) begin
               st_nxt   = ST_RUN;
               wreq_nxt = WAKE_REQ_CYC;
            end
         end
         default: st_nxt = ST_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // power and clock controls follow the next mode
   always_comb begin
      sclk_nxt     = !lpm_is_low(st_nxt);
      osc_nxt      = !lpm_is_low(st_nxt);
      lposc_nxt    = !lpm_is_low(st_nxt) || (wk.flags != 5'h00);
      halt_nxt     = lpm_is_low(st_nxt);
      vreg_nxt     = (st_nxt != ST_SLEEP);
      ram_nxt      = (st_nxt == ST_SLEEP);
      lpwr_nxt     = (st_nxt != ST_SLEEP);
      ana_nxt      = (st_nxt != ST_SLEEP);
      cmp_nxt      = 1'b1;
      hold_pin_nxt = (st_nxt == ST_SLEEP);
      pm_nxt       = en_nxt[1];
      wreq_n_nxt   = (wreq_nxt == 4'h0);
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_r       <= ST_RUN;
         hold_r     <= 2'h0;
         wreq_r     <= 4'h0;
         en_r       <= 4'h0;
         clr_r      <= 1'b0;
         rdata_r    <= 32'h0;
         rdy_r      <= 1'b0;
         err_r      <= 1'b0;
         sclk_r     <= 1'b1;
         osc_r      <= 1'b1;
         lposc_r    <= 1'b1;
         halt_r     <= 1'b0;
         vreg_r     <= 1'b1;
         ram_r      <= 1'b0;
         lpwr_r     <= 1'b1;
         ana_r      <= 1'b1;
         cmp_r      <= 1'b1;
         hold_pin_r <= 1'b0;
         pm_r       <= 1'b0;
         wreq_n_r   <= 1'b1;
      end else begin
         st_r       <= st_nxt;
         hold_r     <= hold_nxt;
         wreq_r     <= wreq_nxt;
         en_r       <= en_nxt;
         clr_r      <= clr_nxt;
         rdata_r    <= rdata_nxt;
         rdy_r      <= rdy_nxt;
         err_r      <= err_nxt;
         sclk_r     <= sclk_nxt;
         osc_r      <= osc_nxt;
         lposc_r    <= lposc_nxt;
         halt_r     <= halt_nxt;
         vreg_r     <= vreg_nxt;
         ram_r      <= ram_nxt;
         lpwr_r     <= lpwr_nxt;
         ana_r      <= ana_nxt;
         cmp_r      <= cmp_nxt;
         hold_pin_r <= hold_pin_nxt;
         pm_r       <= pm_nxt;
         wreq_n_r   <= wreq_n_nxt;
      end
   end

   assign PRDATA_O        = rdata_r;
   assign PREADY_O        = rdy_r;
   assign PSLVERR_O       = err_r;
   assign SYS_CLK_EN_O    = sclk_r;
   assign OSC_EN_O        = osc_r;
   assign LP_OSC_EN_O     = lposc_r;
   assign CORE_HALT_O     = halt_r;
   assign CORE_REG_EN_O   = vreg_r;
   assign RAM_ON_VDD_O    = ram_r;
   assign LOGIC_PWR_EN_O  = lpwr_r;
   assign ANALOG_EN_O     = ana_r;
   assign CMP_EN_O        = cmp_r;
   assign GPIO_HOLD_O     = hold_pin_r;
   assign PORT_MATCH_EN_O = pm_r;
   assign WAKE_REQ_N_O    = wreq_n_r;

   ////////////////////////////////////////////////////////////////////////////
   a_suspend_gates_clk: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_RUN && wr_cfg && PWDATA_I[SUSP_BIT] && !PWDATA_I[SLEEP_BIT] && wk.flags == 5'h00)
      |=> (!SYS_CLK_EN_O && !OSC_EN_O && CORE_HALT_O))
      else $error("suspend did not gate clock");
   a_refuse_entry: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_RUN && wr_cfg && wk.flags != 5'h00) |=> (st_r == ST_RUN && SYS_CLK_EN_O))
      else $error("low power entered with flag set");
   a_halt_until_wake: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SUSP && !wk.wake && wk.flags == 5'h00) |=> (st_r == ST_SUSP && CORE_HALT_O))
      else $error("suspend left without wake");
   a_flags_zero_hold: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SUSP && $rose(wk.wake)) |=> (st_r == ST_HOLD)[*2] ##1 (st_r == ST_RUN))
      else $error("flag hold window not two clocks");
   a_resume_clock: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SUSP && wk.wake) |=> (SYS_CLK_EN_O && OSC_EN_O && !CORE_HALT_O))
      else $error("clock not restored on wake");
   a_sleep_power: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SLEEP) |-> (!CORE_REG_EN_O && RAM_ON_VDD_O && !LOGIC_PWR_EN_O && CMP_EN_O))
      else $error("sleep power state wrong");
   a_pins_hold: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SLEEP) |-> (GPIO_HOLD_O && !ANALOG_EN_O))
      else $error("pins not held in sleep");
   a_wake_req_low: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SLEEP && st_nxt == ST_RUN) |=> (!WAKE_REQ_N_O)[*7] ##1 !WAKE_REQ_N_O ##1 WAKE_REQ_N_O)
      else $error("wake request pulse wrong");
   a_trigger_reads_zero: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (PREADY_O && PSEL_I && !PWRITE_I) |-> (PRDATA_O[SLEEP_BIT:CLEAR_BIT] == 3'h0))
      else $error("trigger bits read nonzero");

   ////////////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && !PENABLE_I) |=> PREADY_O)
      else $error("no ready after setup cycle");
   a_ready_one_cycle: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      PREADY_O |=> !PREADY_O)
      else $error("ready held beyond one cycle");
   a_err_unmapped: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && !PENABLE_I && PADDR_I != CFG_OFS && PADDR_I != STAT_OFS) |=> (PSLVERR_O && PRDATA_O == 32'h0))
      else $error("unmapped access not refused");
   a_no_err_mapped: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && !PENABLE_I && (PADDR_I == CFG_OFS || PADDR_I == STAT_OFS)) |=> !PSLVERR_O)
      else $error("error on mapped address");
   a_enable_port_match: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (wr_cfg && PWDATA_I[1]) |=> PORT_MATCH_EN_O)
      else $error("port match enable not applied");
   a_sleep_entry: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_RUN && wr_cfg && PWDATA_I[SLEEP_BIT] && wk.flags == 5'h00)
      |=> (st_r == ST_SLEEP && !CORE_REG_EN_O && RAM_ON_VDD_O))
      else $error("sleep request not taken");
   a_sleep_stays: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SLEEP && !wk.wake && wk.flags == 5'h00) |=> (st_r == ST_SLEEP && !LOGIC_PWR_EN_O))
      else $error("sleep left without wake");
   a_sleep_exit_run: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SLEEP && wk.wake) |=> (st_r == ST_RUN && CORE_REG_EN_O && LOGIC_PWR_EN_O && !GPIO_HOLD_O))
      else $error("sleep exit did not restore power");
   a_lp_osc_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (wk.flags != 5'h00) |=> LP_OSC_EN_O)
      else $error("low power osc off with flag set");
   a_hold_reads_zero: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == CFG_OFS && st_r == ST_HOLD) |=> (PRDATA_O == 32'h0))
      else $error("flags visible in hold window");
   a_hold_count_range: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_HOLD) |-> (hold_r != 2'h0 && hold_r <= FLAG_HOLD_CYC))
      else $error("hold counter out of range");
   a_suspend_power: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SUSP) |-> (CORE_REG_EN_O && !RAM_ON_VDD_O && LOGIC_PWR_EN_O && !GPIO_HOLD_O))
      else $error("suspend power state wrong");
   a_halt_in_low: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_SUSP || st_r == ST_SLEEP) |-> (CORE_HALT_O && !SYS_CLK_EN_O && !OSC_EN_O))
      else $error("core not halted in low power");
   a_run_clock_on: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_RUN) |-> (SYS_CLK_EN_O && OSC_EN_O && !CORE_HALT_O))
      else $error("clock off while running");
   a_entry_needs_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (st_r == ST_RUN && !wr_cfg) |=> (st_r == ST_RUN))
      else $error("low power entered without request");
endmodule : lpm_ctrl

// *** tb_low_power_mode_controller.sv ***
// testbench: self-checking bench of the low power mode controller over apb
`timescale 1ns/1ps
module tb_low_power_mode_controller;
   import lpm_pkg::*;
   logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [5:0]        src;
   logic [3:0]        en;
   logic [9:0]        mv;
   logic              sys_clk_en, osc_en, lp_osc_en, core_halt, core_reg_en, ram_on_vdd;
   logic              logic_pwr_en, analog_en, cmp_en, gpio_hold, port_match_en, wake_req_n;
   int                fail_count, n_compared, cyc, n, s;
   logic [4:0]        fl;
   localparam int     PIN_WAIT_CYC = 3750; // 15 us at 4 ns
   assign mv = {sys_clk_en, osc_en, lp_osc_en, core_halt, core_reg_en, ram_on_vdd,
                logic_pwr_en, analog_en, cmp_en, gpio_hold};
   lpm_ctrl i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .CS_DONE_I(src[4]), .RTC_FAIL_I(src[3]),
      .RTC_ALARM_I(src[2]), .PORT_MATCH_I(src[1]), .CMP0_I(src[0]), .RST_PIN_I(~src[5]),
      .SYS_CLK_EN_O(sys_clk_en), .OSC_EN_O(osc_en), .LP_OSC_EN_O(lp_osc_en),
      .CORE_HALT_O(core_halt), .CORE_REG_EN_O(core_reg_en), .RAM_ON_VDD_O(ram_on_vdd),
      .LOGIC_PWR_EN_O(logic_pwr_en), .ANALOG_EN_O(analog_en), .CMP_EN_O(cmp_en),
      .GPIO_HOLD_O(gpio_hold), .PORT_MATCH_EN_O(port_match_en), .WAKE_REQ_N_O(wake_req_n));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task final_report();
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask : chk
   // one apb transfer, held until pready is seen at a rising edge
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) chk("pready", 32'h1, 32'h0);
   endtask : apb
   // run, suspend, sleep output vectors
   task chk_mode(input int m);
      logic [9:0] e;
      e = (m == 0) ? 10'h3ae : (m == 1) ? 10'h06e : 10'h053;
      chk("mode outputs", {22'h0, e}, {22'h0, mv});
   endtask : chk_mode
   task settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task pulse(input int i, input int w);
      @(posedge clk);
      src[i] <= 1'b1;
      repeat (w) @(posedge clk);
      src[i] <= 1'b0;
   endtask : pulse
   task wake_wait();
      n = 0;
      while (core_halt !== 1'b0 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (4) @(posedge clk);
      #1;
   endtask : wake_wait
   task clear_flags();
      apb(1'b1, CFG_OFS, 32'h20);
      apb(1'b0, CFG_OFS, 32'h0);
      chk("flags after clear", 32'h0, rd);
   endtask : clear_flags
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; src = 6'h00; fail_count = 0; n_compared = 0; cyc = 0;
      void'($urandom(83812));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk_mode(0);
      chk("wake req idle", 32'h1, {31'h0, wake_req_n});
      apb(1'b1, 12'h008, 32'hff);
      chk("slverr write", 32'h1, {31'h0, err});
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped read", 32'h0, rd);
      chk("slverr read", 32'h1, {31'h0, err});
      // each wake source: enter suspend, wake, read flag, refuse re-entry when a flag is set (CS_DONE_I sets none)
      for (s = 0; s < 6; s++) begin
         en = 4'($urandom);
         if (s < 4) en[s] = 1'b1;
         apb(1'b1, CFG_OFS, 32'h40 | {28'h0, en});
         settle();
         chk_mode(1);
         apb(1'b0, STAT_OFS, 32'h0);
         chk("stat in suspend", 32'h1, rd);
         apb(1'b0, CFG_OFS, 32'h0);
         chk("cfg in suspend", 32'h0, rd);
         pulse(s, 1 + $urandom % 3);
         wake_wait();
         chk_mode(0);
         fl = (s < 4) ? 5'(1 << s) : (s == 5) ? 5'h10 : 5'h00;
         apb(1'b0, CFG_OFS, 32'h0);
         chk("wake flags", {27'h0, fl}, rd);
         if (fl != 5'h00) begin
            apb(1'b1, CFG_OFS, 32'h40 | {28'h0, en});
            settle();
            chk("refused entry", 32'h1, {31'h0, lp_osc_en & ~core_halt});
            clear_flags();
         end
      end
      repeat (PIN_WAIT_CYC) @(posedge clk);
      // disabled source must not wake; pin glitch still does
      apb(1'b1, CFG_OFS, 32'h40);
      pulse(2, 2);
      settle();
      chk("disabled alarm", 32'h1, {31'h0, core_halt});
      pulse(5, 1);
      // read lands inside the two cycle flag hold window
      apb(1'b0, CFG_OFS, 32'h0);
      chk("flags in hold", 32'h0, rd);
      wake_wait();
      chk_mode(0);
      apb(1'b0, CFG_OFS, 32'h0);
      chk("pin flag", 32'h10, rd);
      clear_flags();
      // sleep, wake by port match, wake request low width
      en = 4'($urandom) | 4'h2;
      apb(1'b1, CFG_OFS, 32'h80 | {28'h0, en});
      settle();
      chk_mode(2);
      chk("port match en", {31'h0, en[1]}, {31'h0, port_match_en});
      apb(1'b0, STAT_OFS, 32'h0);
      chk("stat in sleep", 32'h2, rd);
      pulse(1, 1);
      n = 0;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (wake_req_n === 1'b0) n++;
      end
      chk("wake req low cycles", {28'h0, WAKE_REQ_CYC}, 32'(n));
      chk_mode(0);
      apb(1'b0, CFG_OFS, 32'h0);
      chk("sleep wake flag", 32'h2, rd);
      clear_flags();
      final_report();
   end
endmodule : tb_low_power_mode_controller
